/* dv/spg_pin_monitor.sv */
// Purpose: board-side view of the status pin, resolving its level
// Assumes: only the device's weak pulls; no external resistor
// Notes: an undriven, unpulled pin toggles each cycle so no stale level hides
`timescale 1ns/10ps
module spg_pin_monitor (
    input wire logic hclk, // Clock for the floating pattern
    input wire logic pin_out, // Pad value from device
    input wire logic pin_oe_n, // Low while device drives
    input wire logic pull_up, // Weak pull-up on
    input wire logic pull_down, // Weak pull-down on
    output logic pin_level // Resolved pin level
);
    logic last_level = 1'b0;
    always @(posedge hclk) begin
        last_level <= pin_level;
    end
    // Floating: show a level that toggles each cycle, not a held last driven one
    always_comb begin
        if (!pin_oe_n) begin
            pin_level = pin_out;
        end else if (pull_up) begin
            pin_level = 1'b1;
        end else if (pull_down) begin
            pin_level = 1'b0;
        end else begin
            pin_level = ~last_level;
        end
    end
endmodule

/* dv/tb_status_pin_and_gpio_status.sv */
// Purpose: self-checking bench for the status pin block
// Assumes: zero wait-state slave, but the master still waits on hready
// Notes: row fields are config, flags, pin enable, pin level, live bit
`timescale 1ns/10ps
module tb_status_pin_and_gpio_status;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hready, hresp, pin_out, pin_oe_n, pull_up, pull_down, clk_en, pin_level;
    logic [10:0] flags = 11'h000;
    logic spi_mode = 1'b0, sda_pin = 1'b1, scl_pin = 1'b1, oe_pin = 1'b1, bond = 1'b1;
    int err_total = 0, num_checks = 0, cycles = 0;
    logic [29:0] rows [27];

    spg_status_pin spg_status_pin_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .analog_loop_settled(flags[0]), .digital_loop_settled(flags[1]),
        .reference0_signal_loss_monitor(flags[2]), .reference1_signal_loss_monitor(flags[3]),
        .crystal_signal_loss_monitor(flags[4]), .reference0_activity_monitor(flags[5]),
        .reference1_activity_monitor(flags[6]), .reference0_unusable(flags[7]),
        .reference1_unusable(flags[8]), .device_int_status(8'h04),
        .device_int_enable(flags[9] ? 8'h0C : 8'h0B), .startup_done(flags[10]),
        .serial_peripheral_mode(spi_mode), .status_pin_in(pin_level),
        .serial_data_pin_in(sda_pin), .serial_clock_pin_in(scl_pin),
        .output_enable_select_pin(oe_pin), .die_bond_option_bit(bond),
        .status_pin_out(pin_out), .status_pin_oe_n(pin_oe_n), .status_pin_pullup(pull_up),
        .status_pin_pulldown(pull_down), .clock_outputs_enable(clk_en));
    spg_pin_monitor spg_pin_monitor_inst (.hclk(hclk), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pull_up(pull_up), .pull_down(pull_down),
        .pin_level(pin_level));

    // ----------------------------------------
    // Clock, timeout and report
    // ----------------------------------------
    initial begin
        forever #20 hclk = ~hclk;
    end
    task automatic end_sim();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Whole run needs under 2000 cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk_bit(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // ----------------------------------------
    // AHB-Lite single word transfer
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= spg_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h0);
        chk_word(name, exp, rd);
        chk_bit("hresp", 1'b0, hresp);
    endtask

    initial begin
        rows = '{{16'h0200, 11'h001, 3'b011}, {16'h0200, 11'h7FE, 3'b000},
            {16'h0201, 11'h002, 3'b011}, {16'h0202, 11'h7FB, 3'b000},
            {16'h0302, 11'h004, 3'b000}, {16'h0203, 11'h008, 3'b011},
            {16'h0204, 11'h010, 3'b011}, {16'h0205, 11'h020, 3'b010},
            {16'h0306, 11'h040, 3'b000}, {16'h0206, 11'h7BF, 3'b000},
            {16'h0207, 11'h080, 3'b010}, {16'h0208, 11'h100, 3'b010},
            {16'h0209, 11'h200, 3'b010}, {16'h0209, 11'h5FF, 3'b000},
            {16'h020A, 11'h400, 3'b010}, {16'h020A, 11'h3FF, 3'b000},
            {16'h021D, 11'h7FF, 3'b000}, {16'h021E, 11'h000, 3'b010},
            {16'h031E, 11'h000, 3'b000}, {16'h031F, 11'h000, 3'b000},
            {16'h030B, 11'h7FF, 3'b010},
            {16'h1200, 11'h001, 3'b110}, {16'h1200, 11'h000, 3'b000},
            {16'h1300, 11'h001, 3'b000}, {16'h1300, 11'h000, 3'b110},
            {16'h0A00, 11'h000, 3'b110}, {16'h0C00, 11'h001, 3'b100}};
        repeat (10) @(posedge hclk);
        chk_bit("pullup in reset", 1'b1, pull_up);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        rd_chk(spg_pkg::OFS_PIN_CONFIG, 32'h0000_0200, "config reset");
        rd_chk(spg_pkg::OFS_SCRATCH, 32'h0, "scratch reset");
        rd_chk(spg_pkg::OFS_STARTUP, 32'h0000_008E, "startup status");
        bond <= 1'b0;
        sda_pin <= 1'b0;
        repeat (4) @(posedge hclk);
        rd_chk(spg_pkg::OFS_STARTUP, 32'h0000_000E, "startup later");
        // ----------------------------------------
        // Source, polarity and pad mode table
        // ----------------------------------------
        foreach (rows[i]) begin
            flags <= rows[i][13:3];
            bus(1'b1, spg_pkg::OFS_PIN_CONFIG, {16'h0, rows[i][29:14]});
            repeat (3) @(posedge hclk);
            chk_bit("pin enable", rows[i][2], pin_oe_n);
            chk_bit("pin level", rows[i][1], pin_level);
            if (rows[i][26:25] == 2'b00) begin
                rd_chk(spg_pkg::OFS_LIVE, {30'h0, rows[i][0], 1'b1}, "live");
            end
        end
        // ----------------------------------------
        // Reserved bits, scratch, unmapped space
        // ----------------------------------------
        bus(1'b1, spg_pkg::OFS_PIN_CONFIG, 32'hFFFF_FFFF);
        rd_chk(spg_pkg::OFS_PIN_CONFIG, 32'h0000_1F1F, "config mask");
        bus(1'b1, spg_pkg::OFS_PIN_CONFIG, 32'h0000_0200);
        bus(1'b1, spg_pkg::OFS_SCRATCH, 32'hA5C3_0FF1);
        rd_chk(spg_pkg::OFS_SCRATCH, 32'hA5C3_0FF1, "scratch");
        chk_bit("pin after scratch", 1'b1, pin_level);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd_chk(8'h20, 32'h0, "unmapped");
        // ----------------------------------------
        // Output-enable pin, select and SPI mode
        // ----------------------------------------
        oe_pin <= 1'b0;
        repeat (4) @(posedge hclk);
        chk_bit("clock enable", 1'b0, clk_en);
        rd_chk(spg_pkg::OFS_LIVE, 32'h0000_0002, "live oe low");
        spi_mode <= 1'b1;
        repeat (4) @(posedge hclk);
        chk_bit("clock enable spi", 1'b1, clk_en);
        spi_mode <= 1'b0;
        bus(1'b1, spg_pkg::OFS_OE_CTRL, 32'h0000_0001);
        repeat (4) @(posedge hclk);
        chk_bit("clock enable sel", 1'b1, clk_en);
        oe_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        rd_chk(spg_pkg::OFS_LIVE, 32'h0000_0002, "live oe sel");
        // Second reset in mid-run clears the written state
        bus(1'b1, spg_pkg::OFS_PIN_CONFIG, 32'h0000_0400);
        @(posedge hclk);
        chk_bit("pulldown set", 1'b1, pull_down);
        chk_bit("pullup cleared", 1'b0, pull_up);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        chk_bit("pulldown in reset", 1'b0, pull_down);
        chk_bit("pullup rereset", 1'b1, pull_up);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        rd_chk(spg_pkg::OFS_SCRATCH, 32'h0, "scratch rereset");
        rd_chk(spg_pkg::OFS_PIN_CONFIG, 32'h0000_0200, "config rereset");
        rd_chk(spg_pkg::OFS_OE_CTRL, 32'h0, "oe select rereset");
        end_sim();
    end
endmodule

/* logic/spg_pkg.sv */
// Purpose: constants for the status pin and pin status block
// Assumes: AHB-Lite register access, one word per register
// Notes: offsets are byte addresses
package spg_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_PIN_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STARTUP = 8'h04;
    localparam logic [7:0] OFS_LIVE = 8'h08;
    localparam logic [7:0] OFS_SCRATCH = 8'h0C;
    localparam logic [7:0] OFS_OE_CTRL = 8'h10;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int POS_OPEN_DRAIN = 12;
    localparam int POS_HIZ = 11;
    localparam int POS_PULLDOWN = 10;
    localparam int POS_PULLUP = 9;
    localparam int POS_POL = 8;
    localparam int POS_BOND = 7;
    localparam int POS_LIVE_STATUS = 1;
    localparam int POS_LIVE_OE = 0;
    // ----------------------------------------
    // Reset values, masks and startup capture delay
    // ----------------------------------------
    localparam logic [15:0] RST_PIN_CONFIG = 16'h0200;
    localparam logic [15:0] MASK_PIN_CONFIG = 16'h1F1F;
    localparam logic [31:0] RST_SCRATCH = 32'h0000_0000;
    localparam logic RST_OE_SELECT = 1'h0;
    localparam logic [3:0] STARTUP_CAPTURE_DELAY = 4'h3;
    // ----------------------------------------
    // Source select codes and AHB transfer type
    // ----------------------------------------
    localparam logic [4:0] SEL_ANALOG_LOCK = 5'h00;
    localparam logic [4:0] SEL_DIGITAL_LOCK = 5'h01;
    localparam logic [4:0] SEL_REF0_LOSS = 5'h02;
    localparam logic [4:0] SEL_REF1_LOSS = 5'h03;
    localparam logic [4:0] SEL_XTAL_LOSS = 5'h04;
    localparam logic [4:0] SEL_REF0_ACT = 5'h05;
    localparam logic [4:0] SEL_REF1_ACT = 5'h06;
    localparam logic [4:0] SEL_REF0_BAD = 5'h07;
    localparam logic [4:0] SEL_REF1_BAD = 5'h08;
    localparam logic [4:0] SEL_DEVICE_INT = 5'h09;
    localparam logic [4:0] SEL_READY = 5'h0A;
    localparam logic [4:0] SEL_LOW = 5'h1D;
    localparam logic [4:0] SEL_HIGH = 5'h1E;
    localparam logic [4:0] SEL_NO_POL = 5'h1F;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* logic/spg_status_pin.sv */
// Purpose: status pin source select, pad control, pin readback, scratch
// Assumes: single hclk domain; status flags synchronous to hclk
// Notes: pin inputs pass two flip-flops; zero wait-state AHB-Lite slave
//
// Behaviour
// - Open-drain bit 12 makes the status pin open-drain instead of push-pull.
// - Open-drain: drive low for output zero, release for one, after polarity.
// - Tristate bit 11 holds the status pin in high impedance.
// - Bit 10 enables pull-down; avoid with open-drain.
// - Bit 9 enables pull-up and resets to one.
// - Polarity bit 8: zero drives signal unchanged, one drives inverse.
// - Polarity is ignored when source select equals 0x1F.
// - Codes 0x0-0x4 select loop settled and loss-of-signal flags.
// - Codes 0x5-0x8 select activity monitor and unusable reference flags.
// - Code 0x9 drives masked interrupt; 0xA drives startup done.
// - Code 0x1D forces low, 0x1E forces high; others reserved.
// - Startup status bit 7 returns the bond option pad level.
// - Startup status bits 3:0 hold pin levels captured at startup.
// - Live bit 1 mirrors status pin for select 0x0-0x4, else zero.
// - Live bit 0 mirrors enable pin when select zero, else zero.
// - Thirty-two bit scratch register, reset zero, no hardware effect.
// - Enable select one ignores enable pin; zero lets it disable outputs.
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module spg_status_pin #(
    parameter int INT_WIDTH = 8 // Interrupt source count
) (
    input wire logic hclk, // Bus clock, 25 MHz
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [7:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic hready, // Bus ready in
    input wire logic [31:0] hwdata, // Write data
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    input wire logic analog_loop_settled, // Analog loop settled flag
    input wire logic digital_loop_settled, // Digital loop settled flag
    input wire logic reference0_signal_loss_monitor, // Ref 0 loss
    input wire logic reference1_signal_loss_monitor, // Ref 1 loss
    input wire logic crystal_signal_loss_monitor, // Crystal loss
    input wire logic reference0_activity_monitor, // Ref 0 activity
    input wire logic reference1_activity_monitor, // Ref 1 activity
    input wire logic reference0_unusable, // Ref 0 invalid
    input wire logic reference1_unusable, // Ref 1 invalid
    input wire logic [INT_WIDTH-1:0] device_int_status, // Interrupt status
    input wire logic [INT_WIDTH-1:0] device_int_enable, // Interrupt enable
    input wire logic startup_done, // Startup sequence completed
    input wire logic serial_peripheral_mode, // Serial port in SPI mode
    input wire logic status_pin_in, // Status pad input level
    input wire logic serial_data_pin_in, // Serial data pad level
    input wire logic serial_clock_pin_in, // Serial clock pad level
    input wire logic output_enable_select_pin, // Output-enable pad level
    input wire logic die_bond_option_bit, // Bond option pad
    output logic status_pin_out, // Status pad output value
    output logic status_pin_oe_n, // Status pad enable, low drives
    output logic status_pin_pullup, // Pull-up enable
    output logic status_pin_pulldown, // Pull-down enable
    output logic clock_outputs_enable // Clock output drivers enable
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end else begin
            pin_meta <= {die_bond_option_bit, output_enable_select_pin, serial_clock_pin_in,
                         serial_data_pin_in, status_pin_in};
            pin_sync <= pin_meta;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] pin_config;
    logic [31:0] software_scratch_value;
    logic oe_select;
    logic [3:0] pins_captured_at_boot;
    logic [3:0] boot_count;
    logic boot_captured;
    logic [4:0] sel;
    logic addr_valid;
    logic [7:0] addr_q;
    logic write_q;

    assign sel = pin_config[4:0];

    // Address phase held for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_valid <= 1'b0;
            addr_q <= 8'h00;
            write_q <= 1'b0;
        end else if (hready) begin
            addr_valid <= hsel && (htrans == spg_pkg::HTRANS_NONSEQ || htrans == 2'h3);
            addr_q <= haddr;
            write_q <= hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_config <= spg_pkg::RST_PIN_CONFIG;
        end else if (addr_valid && write_q && addr_q == spg_pkg::OFS_PIN_CONFIG) begin
            pin_config <= hwdata[15:0] & spg_pkg::MASK_PIN_CONFIG;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            software_scratch_value <= spg_pkg::RST_SCRATCH;
        end else if (addr_valid && write_q && addr_q == spg_pkg::OFS_SCRATCH) begin
            software_scratch_value <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_select <= spg_pkg::RST_OE_SELECT;
        end else if (addr_valid && write_q && addr_q == spg_pkg::OFS_OE_CTRL) begin
            oe_select <= hwdata[0];
        end
    end

    // Capture after synchronisers have filled, once per reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_count <= 4'h0;
            boot_captured <= 1'b0;
            pins_captured_at_boot <= 4'h0;
        end else if (!boot_captured) begin
            if (boot_count == spg_pkg::STARTUP_CAPTURE_DELAY) begin
                boot_captured <= 1'b1;
                pins_captured_at_boot <= pin_sync[3:0];
            end else begin
                boot_count <= boot_count + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // Status pin source and pad control
    // ----------------------------------------
    logic source;
    logic next_value;
    always_comb begin
        case (sel)
            spg_pkg::SEL_ANALOG_LOCK: source = analog_loop_settled;
            spg_pkg::SEL_DIGITAL_LOCK: source = digital_loop_settled;
            spg_pkg::SEL_REF0_LOSS: source = reference0_signal_loss_monitor;
            spg_pkg::SEL_REF1_LOSS: source = reference1_signal_loss_monitor;
            spg_pkg::SEL_XTAL_LOSS: source = crystal_signal_loss_monitor;
            spg_pkg::SEL_REF0_ACT: source = reference0_activity_monitor;
            spg_pkg::SEL_REF1_ACT: source = reference1_activity_monitor;
            spg_pkg::SEL_REF0_BAD: source = reference0_unusable;
            spg_pkg::SEL_REF1_BAD: source = reference1_unusable;
            spg_pkg::SEL_DEVICE_INT: source = |(device_int_status & device_int_enable);
            spg_pkg::SEL_READY: source = startup_done;
            spg_pkg::SEL_LOW: source = 1'b0;
            spg_pkg::SEL_HIGH: source = 1'b1;
            default: source = 1'b0; // Reserved codes source low; polarity bit still inverts it except for 0x1F
        endcase
        if (sel == spg_pkg::SEL_NO_POL) begin
            next_value = source;
        end else begin
            next_value = source ^ pin_config[spg_pkg::POS_POL];
        end
    end

    logic value_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value_q <= 1'b0;
        end else begin
            value_q <= next_value;
        end
    end

    logic od;
    logic hiz;
    assign od = pin_config[spg_pkg::POS_OPEN_DRAIN];
    assign hiz = pin_config[spg_pkg::POS_HIZ];
    // Open-drain only ever drives zero, so value is forced low when driving
    assign status_pin_out = od ? 1'b0 : value_q;
    assign status_pin_oe_n = hiz | (od & value_q);
    // Pull-down with open-drain is left to software to avoid
    assign status_pin_pulldown = pin_config[spg_pkg::POS_PULLDOWN];
    assign status_pin_pullup = pin_config[spg_pkg::POS_PULLUP];

    // Output enable pin gates the clock drivers except in SPI mode or when enable select is one
    assign clock_outputs_enable = oe_select | serial_peripheral_mode | pin_sync[3];

    // ----------------------------------------
    // Readback
    // ----------------------------------------
    logic [7:0] live_status;
    always_comb begin
        live_status = 8'h00;
        live_status[spg_pkg::POS_LIVE_STATUS] = (sel <= spg_pkg::SEL_XTAL_LOSS) & value_q;
        live_status[spg_pkg::POS_LIVE_OE] = ~oe_select & pin_sync[3];
    end

    logic [31:0] read_word;
    always_comb begin
        if (addr_q == spg_pkg::OFS_PIN_CONFIG) begin
            read_word = {16'h0000, pin_config};
        end else if (addr_q == spg_pkg::OFS_STARTUP) begin
            read_word = {24'h000000, pin_sync[4], 3'h0, pins_captured_at_boot};
        end else if (addr_q == spg_pkg::OFS_LIVE) begin
            read_word = {24'h000000, live_status};
        end else if (addr_q == spg_pkg::OFS_SCRATCH) begin
            read_word = software_scratch_value;
        end else if (addr_q == spg_pkg::OFS_OE_CTRL) begin
            read_word = {31'h00000000, oe_select};
        end else begin
            read_word = 32'h0000_0000;
        end
    end
    assign hrdata = (addr_valid && !write_q) ? read_word : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_od_never_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (od && !status_pin_oe_n) |-> !status_pin_out)
        else $error("open drain drove high");
    a_od_release: assert property (@(posedge hclk) disable iff (!hresetn)
        (od && !hiz) |-> (status_pin_oe_n == value_q))
        else $error("open drain release wrong");
    a_hiz_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        hiz |-> status_pin_oe_n)
        else $error("tristate not honoured");
    a_forced_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel == spg_pkg::SEL_HIGH && $stable(sel) && !pin_config[spg_pkg::POS_POL])
        |=> value_q || sel != spg_pkg::SEL_HIGH)
        else $error("forced high missing");
    a_pol_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel == spg_pkg::SEL_NO_POL) |=> !value_q)
        else $error("polarity applied to 0x1F");
    a_pol_invert: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && sel == spg_pkg::SEL_ANALOG_LOCK)
        |=> value_q == ($past(analog_loop_settled)
        ^ $past(pin_config[spg_pkg::POS_POL])))
        else $error("polarity wrong");
    a_live_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel > spg_pkg::SEL_XTAL_LOSS) |-> !live_status[spg_pkg::POS_LIVE_STATUS])
        else $error("live status not zero");
    a_oe_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        oe_select |-> !live_status[spg_pkg::POS_LIVE_OE])
        else $error("oe readback not zero");
    a_scratch_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        !(addr_valid && write_q) |=> $stable(software_scratch_value))
        else $error("scratch changed without write");
    a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (pin_config & ~spg_pkg::MASK_PIN_CONFIG) == 16'h0000)
        else $error("reserved bits set");
    a_clk_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (!oe_select && !serial_peripheral_mode && !pin_sync[3]) |-> !clock_outputs_enable)
        else $error("clock outputs not disabled");

    // ----------------------------------------
    // Routing and readback checks
    // ----------------------------------------
    // Routing checks skip the release edge, whose update still came from reset
    a_digital_route: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && sel == spg_pkg::SEL_DIGITAL_LOCK && !pin_config[spg_pkg::POS_POL])
        |=> value_q == $past(digital_loop_settled))
        else $error("digital loop flag not routed");

    a_xtal_route: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && sel == spg_pkg::SEL_XTAL_LOSS && !pin_config[spg_pkg::POS_POL])
        |=> value_q == $past(crystal_signal_loss_monitor))
        else $error("crystal loss flag not routed");

    a_act_route: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && sel == spg_pkg::SEL_REF0_ACT && !pin_config[spg_pkg::POS_POL])
        |=> value_q == $past(reference0_activity_monitor))
        else $error("activity flag not routed");

    a_bad_route: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && sel == spg_pkg::SEL_REF1_BAD && !pin_config[spg_pkg::POS_POL])
        |=> value_q == $past(reference1_unusable))
        else $error("unusable reference flag not routed");

    a_int_route: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && sel == spg_pkg::SEL_DEVICE_INT && !pin_config[spg_pkg::POS_POL])
        |=> value_q == |($past(device_int_status) & $past(device_int_enable)))
        else $error("masked interrupt not routed");

    a_ready_route: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && sel == spg_pkg::SEL_READY && !pin_config[spg_pkg::POS_POL])
        |=> value_q == $past(startup_done))
        else $error("startup done not routed");

    a_forced_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && sel == spg_pkg::SEL_LOW && !pin_config[spg_pkg::POS_POL]) |=> !value_q)
        else $error("forced low missing");

    a_push_pull: assert property (@(posedge hclk) disable iff (!hresetn)
        (!od && !hiz) |-> (!status_pin_oe_n && status_pin_out == value_q))
        else $error("push-pull drive wrong");

    a_live_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel <= spg_pkg::SEL_XTAL_LOSS && !od && !hiz)
        |-> live_status[spg_pkg::POS_LIVE_STATUS] == status_pin_out)
        else $error("live status not mirrored");

    a_oe_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
        !oe_select |-> live_status[spg_pkg::POS_LIVE_OE] == pin_sync[3])
        else $error("oe readback not mirrored");

    a_oe_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
        oe_select |-> clock_outputs_enable)
        else $error("enable pin not ignored");

    a_boot_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        boot_captured |=> $stable(pins_captured_at_boot))
        else $error("boot capture changed");

    a_bond_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_valid && !write_q && addr_q == spg_pkg::OFS_STARTUP)
        |-> hrdata[spg_pkg::POS_BOND] == pin_sync[4])
        else $error("bond option not returned");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    c_open_drain: cover property (@(posedge hclk) disable iff (!hresetn) od && status_pin_oe_n);
    c_interrupt: cover property (@(posedge hclk) disable iff (!hresetn)
        sel == spg_pkg::SEL_DEVICE_INT && value_q);
    c_boot: cover property (@(posedge hclk) disable iff (!hresetn) $rose(boot_captured));
    c_tristate: cover property (@(posedge hclk) disable iff (!hresetn)
        hiz && status_pin_pulldown);
    c_oe_ignored: cover property (@(posedge hclk) disable iff (!hresetn)
        oe_select && !pin_sync[3]);
endmodule
